/* dv/dtrp_ctrl_tb_top.sv */
// Self-checking bench for the DRAM timing, refresh and parity block
`timescale 1ns/1ps
`default_nettype none
module dtrp_ctrl_tb_top
   import dtrp_pkg::*;
;
   // ****************************************************************
   // Signals and case table
   // ****************************************************************
   typedef struct {
      logic [7:0]  cpu;
      logic [7:0]  alt;
      logic        am;
      dtrp_kind_t  k;
      logic [7:0]  ctrl;
      logic [26:0] a;
      int          extra;
   } dtrp_row_t;
   // Extra clocks over the same access with both timing registers at zero
   dtrp_row_t   rows [10] = '{
      '{8'h01, 8'h00, 1'b0, DTRP_RD_BURST,  8'h00, 27'h0010100, 4},
      '{8'h02, 8'h00, 1'b0, DTRP_RD_BURST,  8'h00, 27'h0020100, 8},
      '{8'h03, 8'h00, 1'b0, DTRP_RD_BURST,  8'h00, 27'h0030100, 8},
      '{8'h40, 8'h00, 1'b0, DTRP_WR_BURST,  8'h00, 27'h0040100, 4},
      '{8'h10, 8'h00, 1'b0, DTRP_WR_SINGLE, 8'h00, 27'h0050100, 1},
      '{8'h04, 8'h00, 1'b0, DTRP_RD_BURST,  8'h00, 27'h0060100, 1},
      '{8'h20, 8'h00, 1'b0, DTRP_WR_SINGLE, 8'h00, 27'h0070100, 1},
      '{8'h02, 8'h00, 1'b1, DTRP_RD_BURST,  8'h02, 27'h7e80100, 0},
      '{8'h00, 8'h40, 1'b1, DTRP_WR_BURST,  8'h00, 27'h0090100, 4},
      '{8'h00, 8'h10, 1'b1, DTRP_WR_SINGLE, 8'h00, 27'h00a0100, 1}
   };
   logic [11:0] regs [4]      = '{ADDR_CPU_TIMING, ADDR_ALT_TIMING, ADDR_CTRL, ADDR_STATUS};
   logic [7:0]  reg_rst [4]   = '{TIMING_RESET, TIMING_RESET, CTRL_RESET, 8'h00};
   logic        pclk          = 1'b0;
   logic        presetn       = 1'b0;
   logic        psel          = 1'b0;
   logic        penable       = 1'b0;
   logic        pwrite        = 1'b0;
   logic [11:0] paddr         = 12'h000;
   logic [31:0] pwdata        = 32'h0;
   dtrp_req_t   req           = '0;
   dtrp_word_t  wr_word       = '{data: 32'hff80_0301, par: 4'ha};
   logic        refresh_pulse = 1'b0;
   logic        isa_busy      = 1'b0;
   logic        bad_par       = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, req_ack, cyc_done, wait_state, parity_error, err;
   logic        isa_refresh_ack, ma_drive, page_hit;
   logic        ws_seen       = 1'b0;
   logic        ref_seen      = 1'b0;
   logic [7:0]  ras_acc       = 8'hff;
   logic [3:0]  wr_par, cas_n;
   logic [7:0]  ras_n;
   logic [26:0] eff_addr;
   dtrp_word_t  rd_word;
   int          mismatches    = 0;
   int          checks_done   = 0;
   int          perr_seen     = 0;
   int          len, base;

   dtrp_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req(req), .req_ack(req_ack), .cyc_done(cyc_done),
      .wait_state(wait_state), .wr_word(wr_word), .rd_word(rd_word), .wr_par(wr_par),
      .parity_error(parity_error), .refresh_pulse(refresh_pulse), .isa_busy(isa_busy),
      .isa_refresh_ack(isa_refresh_ack), .ras_n(ras_n), .cas_n(cas_n),
      .ma_drive(ma_drive), .page_hit(page_hit), .eff_addr(eff_addr));
   dtrp_dram_model dram (.pclk(pclk), .cas_n(cas_n), .bad_par(bad_par), .rd_word(rd_word));

   always #2 pclk = ~pclk;

   // Refresh request is a one-clock pulse, as the link decoder delivers it
   always @(posedge pclk) begin
      if (refresh_pulse === 1'b1) refresh_pulse <= 1'b0;
      if (parity_error === 1'b1) perr_seen++;
      if (wait_state === 1'b1) ws_seen = 1'b1;
      if (ras_n === 8'h00) ref_seen = 1'b1;
      ras_acc = ras_acc & ras_n;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic complete_run;
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_out;
      mismatches++;
      $display("mismatch at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      complete_run();
   endtask

   function automatic logic [3:0] even_par(input logic [31:0] d);
      return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) wait_out();
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic run_cyc(input dtrp_kind_t k, input logic am, input logic [26:0] a);
      int n;
      n = 0;
      req <= '{valid: 1'b1, alt: am, kind: k, bank: 2'h0, addr: a};
      do begin
         @(posedge pclk);
         n++;
      end while (req_ack !== 1'b1 && n < 200);
      req <= '0;
      len = 0;
      while (cyc_done !== 1'b1 && len < 200) begin
         @(posedge pclk);
         len++;
      end
      if (n >= 200 || len >= 200) wait_out();
   endtask

   task automatic do_ref(input int exp_low);
      int n;
      n = 0;
      refresh_pulse <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (ras_n === 8'hff && n < 50);
      chk(32'(ras_n), 32'h5a);
      chk(32'({cas_n, ma_drive}), 32'h0);
      while (ras_n !== 8'h00 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      while (ras_n === 8'h00 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n), 32'(exp_low));
   endtask

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      int n;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      run_cyc(DTRP_RD_BURST, 1'b0, 27'h0);
      // Interleave stays off: no equal odd/even bank pair exists here
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, ADDR_CPU_TIMING, 32'h0);
         apb(1'b1, ADDR_ALT_TIMING, 32'h0);
         apb(1'b1, ADDR_CTRL, {24'h0, rows[i].ctrl});
         run_cyc(rows[i].k, rows[i].am, rows[i].a ^ 27'h0008000);
         base = len;
         apb(1'b1, ADDR_CPU_TIMING, {24'h0, rows[i].cpu});
         apb(1'b1, ADDR_ALT_TIMING, {24'h0, rows[i].alt});
         run_cyc(rows[i].k, rows[i].am, rows[i].a);
         chk(32'(len - base), 32'(rows[i].extra));
         chk(32'(eff_addr), 32'(rows[i].ctrl[F_DEEP256] ? rows[i].a & ~27'h7e00000 : rows[i].a));
         if (rows[i].k != DTRP_RD_BURST) begin
            chk(32'(wr_par), 32'(rows[i].am ? even_par(wr_word.data) : wr_word.par));
         end
      end
      chk(32'(perr_seen), 32'h0);
      $display("test timing table done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'({ras_n, cas_n}), 32'hfff);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, regs[i], 32'h0);
         chk(rd, {24'h0, reg_rst[i]});
      end
      apb(1'b1, ADDR_ALT_TIMING, 32'hffff_fff1);
      apb(1'b0, ADDR_ALT_TIMING, 32'h0);
      chk(rd, 32'h0000_00f1);
      apb(1'b0, 12'h100, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset and registers done");
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, ADDR_CPU_TIMING, {24'h0, j[0], 7'h0});
         do_ref(3 + j);
      end
      ws_seen = 1'b0;
      ref_seen = 1'b0;
      refresh_pulse <= 1'b1;
      @(posedge pclk);
      run_cyc(DTRP_RD_BURST, 1'b1, 27'h0001000);
      chk(32'({ws_seen, ref_seen}), 32'h3);
      $display("test refresh done");
      apb(1'b1, ADDR_CTRL, 32'h1);
      isa_busy <= 1'b1;
      ref_seen = 1'b0;
      refresh_pulse <= 1'b1;
      repeat (12) @(posedge pclk);
      chk(32'({ref_seen, isa_refresh_ack}), 32'h2);
      isa_busy <= 1'b0;
      n = 0;
      while (isa_refresh_ack !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(isa_refresh_ack), 32'h1);
      $display("test isa refresh done");
      apb(1'b1, ADDR_CTRL, 32'h4);
      ras_acc = 8'hff;
      run_cyc(DTRP_RD_BURST, 1'b0, 27'h0001000);
      chk(32'(ras_acc), 32'hfd);
      run_cyc(DTRP_RD_BURST, 1'b0, 27'h0001800);
      chk(32'(page_hit), 32'h1);
      $display("test interleave and page done");
      bad_par <= 1'b1;
      perr_seen = 0;
      run_cyc(DTRP_RD_BURST, 1'b0, 27'h0002000);
      bad_par <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(perr_seen > 0), 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h10);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h0);
      $display("test parity error done");
      complete_run();
   end
endmodule
`default_nettype wire

/* dv/dtrp_dram_model.sv */
// Far-side DRAM bank model: read data carrying even byte parity
`timescale 1ns/1ps
`default_nettype none
module dtrp_dram_model
   import dtrp_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic [3:0] cas_n,
   input  wire logic       bad_par,
   output var  dtrp_word_t rd_word
);
   logic      [31:0] data_reg = 32'h0103_07ff;
   wire logic [3:0]  good_par;

   assign good_par = {^data_reg[31:24], ^data_reg[23:16], ^data_reg[15:8], ^data_reg[7:0]};

   // Data walks every clock, so a capture on the wrong edge is not hidden by a held value
   always @(posedge pclk) begin
      data_reg <= {data_reg[30:0], data_reg[31]} ^ 32'h0000_0100;
   end

   // Corruption is applied only while a column strobe is low, so it lands in a read, a write or a refresh
   assign rd_word.data = data_reg;
   assign rd_word.par  = good_par ^ {3'h0, bad_par & ~(&cas_n)};
endmodule
`default_nettype wire

/* verilog/dtrp_ctrl.sv */
// DRAM timing sequencer, two-set staggered CAS-before-RAS refresh and byte parity
`timescale 1ns/1ps
`default_nettype none
module dtrp_ctrl
   import dtrp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire dtrp_req_t   req,
   output logic             req_ack,
   output logic             cyc_done,
   output logic             wait_state,
   input  wire dtrp_word_t  wr_word,
   input  wire dtrp_word_t  rd_word,
   output logic [3:0]       wr_par,
   output logic             parity_error,
   input  wire logic        refresh_pulse,
   input  wire logic        isa_busy,
   output logic             isa_refresh_ack,
   output logic [7:0]       ras_n,
   output logic [3:0]       cas_n,
   output logic             ma_drive,
   output logic             page_hit,
   output logic [26:0]      eff_addr
);

   // ****************************************************************
   // Sequencer state; the status register reads back its busy, refresh and pending flags and the parity error flag
   // ****************************************************************
   typedef enum {S_IDLE, S_PRE, S_R2C, S_ACCESS, S_REFRESH} dtrp_state_t;
   dtrp_state_t state_reg;
   dtrp_kind_t  kind_reg;
   logic [2:0]  cnt_reg;
   logic [1:0]  beat_reg;
   logic [1:0]  bank_reg;
   logic        alt_reg;
   logic        refresh_pend_reg, isa_pend_reg, set1_first_reg;
   logic [3:0]  stage_par_reg;
   logic [31:0] stage_data_reg;
   logic        stage_vld_reg;

   // ****************************************************************
   // Register slave
   // ****************************************************************
   logic [7:0] cpu_timing_reg, alt_timing_reg, ctrl_reg;
   logic       parity_err_reg;
   wire        wr_en   = psel & penable & pwrite;
   wire        hit_cpu = paddr == ADDR_CPU_TIMING;
   wire        hit_alt = paddr == ADDR_ALT_TIMING;
   wire        hit_ctl = paddr == ADDR_CTRL;
   wire        hit_sts = paddr == ADDR_STATUS;
   wire        mapped  = hit_cpu | hit_alt | hit_ctl | hit_sts;
   wire        perr_clr = wr_en & hit_sts & pwdata[F_PERR_CLR];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_timing_reg <= TIMING_RESET;
         alt_timing_reg <= TIMING_RESET;
         ctrl_reg       <= CTRL_RESET;
      end else if (wr_en) begin
         if (hit_cpu) cpu_timing_reg <= pwdata[7:0];
         if (hit_alt) alt_timing_reg <= pwdata[7:0];
         if (hit_ctl) ctrl_reg       <= pwdata[7:0];
      end
   end

   // Zero wait state slave; unmapped addresses answer with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= hit_cpu ? {24'h000000, cpu_timing_reg} :
                    hit_alt ? {24'h000000, alt_timing_reg} :
                    hit_ctl ? {24'h000000, ctrl_reg} :
                    hit_sts ? {27'h0, refresh_pend_reg, state_reg == S_REFRESH,
                               state_reg != S_IDLE, isa_pend_reg, parity_err_reg} :
                    32'h0000_0000;
      end
   end

   // ****************************************************************
   // Timing selection
   // ****************************************************************
   // Latched at cycle start so a register write mid-cycle cannot skew it
   logic [7:0] tset_reg;
   wire  [7:0] tset_sel = req.alt ? alt_timing_reg : cpu_timing_reg;
   wire  [1:0] brd_code = tset_reg[F_BRD_LO +: 2];
   // Reserved read code 3 falls back to the slowest documented rate
   wire  [2:0] brd_add  = (brd_code == BRD_RESV) ? 3'h2 : {1'b0, brd_code};
   wire  [2:0] bwr_add  = {2'h0, tset_reg[F_BWR]};
   wire  [2:0] r2c_cnt  = R2C_BASE + {2'h0, tset_reg[F_R2C]};
   wire  [2:0] pre_cnt  = PRE_BASE + {2'h0, tset_reg[F_PRE]};
   wire  [2:0] ref_cnt  = REF_BASE + {2'h0, tset_reg[F_REF]};
   wire  [2:0] swr_cnt  = SWR_BASE + {2'h0, tset_reg[F_SWR]};
   wire        is_wr    = kind_reg == DTRP_WR_BURST;
   wire  [2:0] beat_add = is_wr ? bwr_add : brd_add;
   wire  [2:0] lead_cnt = LEAD_BASE + beat_add;
   wire  [2:0] beat_cnt = BEAT_BASE + beat_add;

   // ****************************************************************
   // Address aliasing, page and interleave
   // ****************************************************************
   wire        deep256 = ctrl_reg[F_DEEP256];
   wire [26:0] alias_mask = deep256 && !ctrl_reg[F_INTLV] ?
                            27'h01f_ffff : 27'h7ff_ffff;
   wire [26:0] addr_eff = req.addr & alias_mask;
   wire [15:0] page_id  = deep256 ? addr_eff[26:PAGE_LSB_2K]
                                  : {1'b0, addr_eff[26:PAGE_LSB_4K]};
   wire        ilv_bit  = deep256 ? addr_eff[PAGE_LSB_2K] : addr_eff[PAGE_LSB_4K];
   // Interleave bit picks the odd member of the pair when set
   wire [1:0]  bank_sel = ctrl_reg[F_INTLV] ? {req.bank[1], ilv_bit}
                                            : req.bank;
   logic [15:0] open_page_reg;
   logic        page_open_reg;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   wire set1_active = ~ras_n[0] | ~ras_n[2] | ~ras_n[5] | ~ras_n[7];
   wire cnt_done    = cnt_reg == 3'h1;
   wire start_cyc   = state_reg == S_IDLE && req.valid && !refresh_pend_reg;
   wire start_ref   = state_reg == S_IDLE && refresh_pend_reg;
   wire [7:0] set1_mask = 8'ha5;
   wire [7:0] set2_mask = 8'h5a;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= S_IDLE;
         kind_reg      <= DTRP_RD_SINGLE;
         tset_reg      <= TIMING_RESET;
         cnt_reg       <= 3'h0;
         beat_reg      <= 2'h0;
         bank_reg      <= 2'h0;
         ras_n         <= 8'hff;
         cas_n         <= 4'hf;
         ma_drive      <= 1'b0;
         req_ack       <= 1'b0;
         cyc_done      <= 1'b0;
         wait_state    <= 1'b0;
         eff_addr      <= 27'h0;
         page_hit      <= 1'b0;
         open_page_reg <= 16'h0;
         page_open_reg <= 1'b0;
         set1_first_reg <= 1'b1;
         alt_reg       <= 1'b0;
      end else begin
         req_ack  <= start_cyc;
         cyc_done <= 1'b0;
         // Master waits while a refresh is owed or running, never a hold
         wait_state <= refresh_pend_reg | (state_reg == S_REFRESH);
         unique case (state_reg)
            S_IDLE: begin
               if (start_ref) begin
                  // Set one always goes first, as no row strobe is low in idle; CBR with no address
                  ma_drive  <= 1'b0;
                  cas_n     <= 4'h0;
                  set1_first_reg <= ~set1_active;
                  // Refresh length lives in the CPU register, not the last master's set
                  tset_reg  <= cpu_timing_reg;
                  cnt_reg   <= 3'h1;
                  state_reg <= S_REFRESH;
               end else if (start_cyc) begin
                  tset_reg  <= tset_sel;
                  kind_reg  <= req.kind;
                  alt_reg   <= req.alt;
                  bank_reg  <= bank_sel;
                  eff_addr  <= addr_eff;
                  page_hit  <= page_open_reg && open_page_reg == page_id;
                  open_page_reg <= page_id;
                  page_open_reg <= 1'b1;
                  ma_drive  <= 1'b1;
                  cnt_reg   <= PRE_BASE + {2'h0, tset_sel[F_PRE]};
                  state_reg <= S_PRE;
               end
            end
            S_PRE: begin
               if (cnt_done) begin
                  ras_n[bank_reg] <= 1'b0;
                  cnt_reg   <= r2c_cnt;
                  state_reg <= S_R2C;
               end else cnt_reg <= cnt_reg - 3'h1;
            end
            S_R2C: begin
               if (cnt_done) begin
                  cas_n    <= 4'h0;
                  beat_reg <= (kind_reg == DTRP_RD_BURST || is_wr) ? BURST_BEATS : 2'h0;
                  cnt_reg  <= (kind_reg == DTRP_WR_SINGLE) ? swr_cnt : lead_cnt;
                  state_reg <= S_ACCESS;
               end else cnt_reg <= cnt_reg - 3'h1;
            end
            S_ACCESS: begin
               if (cnt_done) begin
                  if (beat_reg == 2'h0) begin
                     ras_n     <= 8'hff;
                     cas_n     <= 4'hf;
                     ma_drive  <= 1'b0;
                     cyc_done  <= 1'b1;
                     state_reg <= S_IDLE;
                  end else begin
                     beat_reg <= beat_reg - 2'h1;
                     cnt_reg  <= beat_cnt;
                  end
               end else cnt_reg <= cnt_reg - 3'h1;
            end
            S_REFRESH: begin
               // Row strobes fall after CAS, first set then second set
               if (cnt_reg == 3'h1) begin
                  ras_n   <= set1_first_reg ? ~set1_mask : ~set2_mask;
                  cnt_reg <= 3'h2;
               end else if (cnt_reg == 3'h2) begin
                  ras_n   <= 8'h00;
                  cnt_reg <= 3'h3;
               end else if (cnt_reg == ref_cnt + 3'h2) begin
                  ras_n     <= 8'hff;
                  cas_n     <= 4'hf;
                  page_open_reg <= 1'b0;
                  state_reg <= S_IDLE;
               end else cnt_reg <= cnt_reg + 3'h1;
            end
         endcase
      end
   end

   // ****************************************************************
   // Refresh requests from the link decoder
   // ****************************************************************
   wire ref_taken = start_ref;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_pend_reg <= 1'b0;
         isa_pend_reg     <= 1'b0;
         isa_refresh_ack  <= 1'b0;
      end else begin
         // A new pulse wins over the taking of the old one
         refresh_pend_reg <= refresh_pulse | (refresh_pend_reg & ~ref_taken);
         isa_pend_reg     <= ctrl_reg[F_ISA_REF] &
                             (refresh_pulse | (isa_pend_reg & isa_busy));
         isa_refresh_ack  <= isa_pend_reg & ~isa_busy & ctrl_reg[F_ISA_REF];
      end
   end

   // ****************************************************************
   // Parity
   // ****************************************************************
   wire [3:0] gen_par;
   wire [3:0] chk_fail;
   // Owner of the cycle in flight; the request may drop before the data moves
   wire       alt_cur = start_cyc ? req.alt : alt_reg;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_par
         assign gen_par[gi]  = ^wr_word.data[8*gi +: 8];
         assign chk_fail[gi] = (^stage_data_reg[8*gi +: 8]) ^ stage_par_reg[gi];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_par         <= 4'h0;
         stage_data_reg <= 32'h0;
         stage_par_reg  <= 4'h0;
         stage_vld_reg  <= 1'b0;
         parity_err_reg <= 1'b0;
         parity_error   <= 1'b0;
      end else begin
         wr_par <= alt_cur ? gen_par : wr_word.par;
         // Captured on the master's edge, checked on the next
         stage_vld_reg  <= state_reg == S_ACCESS && cnt_done && !is_wr
                           && kind_reg != DTRP_WR_SINGLE;
         stage_data_reg <= rd_word.data;
         stage_par_reg  <= rd_word.par;
         parity_err_reg <= (stage_vld_reg & |chk_fail) | (parity_err_reg & ~perr_clr);
         parity_error   <= stage_vld_reg & |chk_fail;
      end
   end

   AST_REF_HELD: assert property (@(posedge pclk) disable iff (!presetn)
      refresh_pend_reg && !ref_taken |=> refresh_pend_reg)
      else $error("Refresh request dropped");
   AST_REF_NO_MA: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == S_REFRESH |-> !ma_drive)
      else $error("Address driven during refresh");
   AST_PERR: assert property (@(posedge pclk) disable iff (!presetn)
      stage_vld_reg && |chk_fail |=> parity_error)
      else $error("Parity error not flagged");
   AST_ISA_ACK: assert property (@(posedge pclk) disable iff (!presetn)
      isa_refresh_ack |-> $past(ctrl_reg[F_ISA_REF]) && !$past(isa_busy))
      else $error("ISA refresh acknowledged while bus busy");
   AST_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == S_REFRESH |=> wait_state)
      else $error("Master not held during refresh");
   AST_PRE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_reg == S_PRE) |-> ras_n == 8'hff [*2])
      else $error("Precharge too short");
   AST_GEN_PAR: assert property (@(posedge pclk) disable iff (!presetn)
      start_cyc && req.alt |=> wr_par == $past(gen_par))
      else $error("Alternate master parity not generated");
   AST_ALIAS: assert property (@(posedge pclk) disable iff (!presetn)
      start_cyc && deep256 && !ctrl_reg[F_INTLV] |=> eff_addr[ALIAS_HI:ALIAS_LO] == 6'h00)
      else $error("Alias bits not ignored");

endmodule
`default_nettype wire

/* verilog/dtrp_pkg.sv */
// Constants, register map and carrier types of the DRAM timing, refresh and parity block
package dtrp_pkg;

   // ****************************************************************
   // Register map (byte addresses; printed indexes times four)
   // ****************************************************************
   localparam logic [7:0]  IDX_CPU_TIMING  = 8'h10;
   localparam logic [7:0]  IDX_ALT_TIMING  = 8'h1e;
   localparam logic [7:0]  IDX_CTRL        = 8'h20;
   localparam logic [7:0]  IDX_STATUS      = 8'h21;
   localparam logic [11:0] ADDR_CPU_TIMING = {2'h0, IDX_CPU_TIMING, 2'h0};
   localparam logic [11:0] ADDR_ALT_TIMING = {2'h0, IDX_ALT_TIMING, 2'h0};
   localparam logic [11:0] ADDR_CTRL       = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [11:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [7:0]  TIMING_RESET    = 8'h00;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;

   // Timing register fields
   localparam int F_BRD_LO = 0;
   localparam int F_R2C    = 2;
   localparam int F_SWR    = 4;
   localparam int F_PRE    = 5;
   localparam int F_BWR    = 6;
   localparam int F_REF    = 7;
   // Control register fields
   localparam int F_ISA_REF = 0;
   localparam int F_DEEP256 = 1;
   localparam int F_INTLV   = 2;
   localparam int F_ODDBANK = 3;
   localparam int F_PERR_CLR = 4;

   // ****************************************************************
   // Timing counts in clocks, burst beat count, reserved read code and address bit positions
   // ****************************************************************
   localparam logic [2:0] LEAD_BASE   = 3'h3;
   localparam logic [2:0] BEAT_BASE   = 3'h2;
   localparam logic [2:0] SWR_BASE    = 3'h3;
   localparam logic [2:0] R2C_BASE    = 3'h2;
   localparam logic [2:0] PRE_BASE    = 3'h2;
   localparam logic [2:0] REF_BASE    = 3'h3;
   localparam logic [1:0] BURST_BEATS = 2'h3;
   localparam logic [1:0] BRD_RESV    = 2'h3;
   localparam int         PAGE_LSB_2K = 11;
   localparam int         PAGE_LSB_4K = 12;
   localparam int         ALIAS_LO    = 21;
   localparam int         ALIAS_HI    = 26;

   typedef enum logic [1:0] {DTRP_RD_BURST, DTRP_WR_BURST, DTRP_WR_SINGLE, DTRP_RD_SINGLE}
      dtrp_kind_t;

   typedef struct packed {
      logic       valid;
      logic       alt;
      dtrp_kind_t kind;
      logic [1:0] bank;
      logic [26:0] addr;
   } dtrp_req_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  par;
   } dtrp_word_t;

endpackage
